// File: src/gpt_pkg.sv
// constants for the general purpose timer block
package gpt_pkg;
    // register addresses (byte addresses as used by the plain port)
    localparam logic [15:0] ADDR_T1_COUNT = 16'h0100;
    localparam logic [15:0] ADDR_T1_PERIOD = 16'h0102;
    localparam logic [15:0] ADDR_T1_CONTROL = 16'h0104;
    localparam logic [15:0] ADDR_LOW_COUNT = 16'h0106;
    localparam logic [15:0] ADDR_HOLDING = 16'h0108;
    localparam logic [15:0] ADDR_HIGH_COUNT = 16'h010a;
    localparam logic [15:0] ADDR_LOW_PERIOD = 16'h010c;
    localparam logic [15:0] ADDR_HIGH_PERIOD = 16'h010e;
    localparam logic [15:0] ADDR_LOW_CONTROL = 16'h0110;
    localparam logic [15:0] ADDR_HIGH_CONTROL = 16'h0112;
    localparam logic [15:0] ADDR_IRQ_FLAGS = 16'h0114;
    localparam logic [15:0] ADDR_IRQ_ENABLES = 16'h0116;
    // control register fields
    localparam int BIT_ENABLE = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PSC_HI = 5;
    localparam int BIT_PSC_LO = 4;
    localparam int BIT_PAIR32 = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_CLK_SRC = 1;
    // implemented bits per control register
    localparam logic [15:0] MASK_T1_CTL = 16'ha076;
    localparam logic [15:0] MASK_LOW_CTL = 16'ha07a;
    localparam logic [15:0] MASK_HIGH_CTL = 16'ha072;
    // reset values
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam int PSC_W = 8;
    localparam logic [PSC_W-1:0] PSC_LIM_1 = 8'h00;
    localparam logic [PSC_W-1:0] PSC_LIM_8 = 8'h07;
    localparam logic [PSC_W-1:0] PSC_LIM_64 = 8'h3f;
    localparam logic [PSC_W-1:0] PSC_LIM_256 = 8'hff;
    // timer indices
    localparam int NUM_TIMERS = 3;
    localparam int IDX_T1 = 0;
    localparam int IDX_LOW = 1;
    localparam int IDX_HIGH = 2;
endpackage

// File: src/gpt_top.sv
// general purpose timers: one 16-bit timer and a 16/32-bit timer pair
//
// Summary of operation
// - timer one prescale 1, 8, 64, 256
// - prescaler cleared by count write while enabled, disable, reset
// - prescaler frozen while timer disabled
// - control write never changes count
// - sleep counting only enabled async external clock
// - sleep counting wraps at period, raises flag
// - period match sets flag, gated by enable
// - flag sticks until software clears it
// - gate falling edge also sets flag
// - timer one control bit layout
// - pair halves: timer or sync counter only
// - low half is low word in 32-bit
// - 32-bit uses low controls, high flag
// - low half registers its prescaler output
// - 32-bit timer wraps at combined period
// - low count read latches high word
// - low count write loads high from holding
// - 32-bit sync counter counts external edges
// - idle-stop bit halts counting in idle
// - gated mode counts cycles while gate high
// - gate fall stops count, keeps value
// - timer mode counts cycles, wraps at period
// - async counter counts external rising edges
// - async counter halts in idle when set
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module gpt_top
    import gpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic t1_pin_i,
    input wire logic pair_pin_i,
    input wire logic high_pin_i,
    output logic [NUM_TIMERS-1:0] irq_o
);
    logic [15:0] cnt [NUM_TIMERS];
    logic [15:0] per [NUM_TIMERS];
    logic [15:0] con [NUM_TIMERS];
    logic [PSC_W-1:0] psc [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] pin_q;
    logic [NUM_TIMERS-1:0] flag;
    logic [NUM_TIMERS-1:0] ie;
    logic [NUM_TIMERS-1:0] tk;
    logic [NUM_TIMERS-1:0] mt;
    logic [NUM_TIMERS-1:0] gfall;
    logic [NUM_TIMERS-1:0] ev;
    logic low_tick_q;
    logic [15:0] hold;
    logic [15:0] next_rdata;
    logic [NUM_TIMERS-1:0] next_flag;
    wire [NUM_TIMERS-1:0] pin = {high_pin_i, pair_pin_i, t1_pin_i};
    wire [15:0] a_cnt [NUM_TIMERS] = '{ADDR_T1_COUNT, ADDR_LOW_COUNT, ADDR_HIGH_COUNT};
    wire [15:0] a_per [NUM_TIMERS] = '{ADDR_T1_PERIOD, ADDR_LOW_PERIOD, ADDR_HIGH_PERIOD};
    wire [15:0] a_con [NUM_TIMERS] = '{ADDR_T1_CONTROL, ADDR_LOW_CONTROL, ADDR_HIGH_CONTROL};
    wire [15:0] mask [NUM_TIMERS] = '{MASK_T1_CTL, MASK_LOW_CTL, MASK_HIGH_CTL};
    wire m32 = con[IDX_LOW][BIT_PAIR32];
    // full 32-bit compare, so a low word match alone never wraps the pair
    wire mm32 = (cnt[IDX_LOW] == per[IDX_LOW]) && (cnt[IDX_HIGH] == per[IDX_HIGH]);
    wire rd_low = rd_i && (addr_i == ADDR_LOW_COUNT);
    wire wr_low = wr_i && (addr_i == ADDR_LOW_COUNT);
    wire wr_flags = wr_i && (addr_i == ADDR_IRQ_FLAGS);

    // prescaler terminal count from the two-bit select
    function automatic logic [PSC_W-1:0] psc_lim(input logic [1:0] sel);
        logic [PSC_W-1:0] r;
        r = PSC_LIM_1;
        unique case (sel)
            2'h0: r = PSC_LIM_1;
            2'h1: r = PSC_LIM_8;
            2'h2: r = PSC_LIM_64;
            2'h3: r = PSC_LIM_256;
        endcase
        return r;
    endfunction

    genvar i;
    generate
        for (i = 0; i < NUM_TIMERS; i++)
        begin : g_tmr
            // in 32-bit mode the high half takes the low half's controls
            wire hi32 = (i == IDX_HIGH) && m32;
            wire [15:0] c = hi32 ? con[IDX_LOW] : con[i];
            wire timer_enable_bit = c[BIT_ENABLE];
            wire clock_source_select = c[BIT_CLK_SRC];
            wire gate = c[BIT_GATE] && !clock_source_select;
            // only timer one offers the asynchronous mode, which runs in sleep
            wire async_ok = (i == IDX_T1) && clock_source_select && !c[BIT_SYNC];
            wire run = timer_enable_bit && !(cpu_idle_i && c[BIT_IDLE_STOP]) && (!cpu_sleep_i || async_ok);
            wire rise = pin[i] && !pin_q[i];
            // external edge, gate level, or every instruction cycle
            wire src = clock_source_select ? rise : (gate ? pin[i] : 1'b1);
            wire wr_c = wr_i && (addr_i == a_cnt[i]);
            wire wr_k = wr_i && (addr_i == a_con[i]);
            wire wrap_p = psc[i] == psc_lim(c[BIT_PSC_HI:BIT_PSC_LO]);
            wire raw = run && src && wrap_p;
            wire own_tk = (i == IDX_LOW) ? low_tick_q : raw;
            assign tk[i] = hi32 ? tk[IDX_LOW] : own_tk;
            assign mt[i] = (m32 && i != IDX_T1) ? mm32 : (cnt[i] == per[i]);
            assign gfall[i] = gate && timer_enable_bit && pin_q[i] && !pin[i];
            assign ev[i] = (tk[i] && mt[i]) || gfall[i];
            // high half advances on low half carry in 32-bit mode
            wire inc = hi32 ? (tk[IDX_LOW] && (mm32 || cnt[IDX_LOW] == CNT_MAX)) : tk[i];
            wire [15:0] cnt_inc = mt[i] ? RST_COUNT : cnt[i] + 16'h0001;
            wire ld_hold = (i == IDX_HIGH) && m32 && wr_low;

            // prescaler: held while off; the disabling control write has already cleared it to zero
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                    psc[i] <= '0;
                else if (wr_k && con[i][BIT_ENABLE] && !wdata_i[BIT_ENABLE])
                    psc[i] <= '0;
                else if (wr_c && timer_enable_bit)
                    psc[i] <= '0;
                else if (run && src)
                    psc[i] <= wrap_p ? '0 : psc[i] + 1'b1;
            end

            // count: only a count write loads it, control writes leave it
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                    cnt[i] <= RST_COUNT;
                else if (ld_hold)
                    cnt[i] <= hold;
                else if (wr_c)
                    cnt[i] <= wdata_i;
                else if (inc)
                    cnt[i] <= cnt_inc;
            end

            // period, control and pin history
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    per[i] <= RST_PERIOD;
                    con[i] <= RST_CONTROL;
                    pin_q[i] <= 1'b0;
                end
                else
                begin
                    if (wr_i && addr_i == a_per[i])
                        per[i] <= wdata_i;
                    if (wr_k)
                        con[i] <= wdata_i & mask[i];
                    pin_q[i] <= pin[i];
                end
            end
        end
    endgenerate

    // flag sources: in 32-bit mode the pair reports on the high flag only
    wire [NUM_TIMERS-1:0] set = {m32 ? ev[IDX_LOW] : ev[IDX_HIGH], ev[IDX_LOW] && !m32, ev[IDX_T1]};
    // write-one-to-clear; a set in the same cycle wins
    assign next_flag = set | (flag & ~(wr_flags ? wdata_i[NUM_TIMERS-1:0] : '0));

    // read mux, answer stands for one cycle only
    always_comb
    begin
        next_rdata = '0;
        if (rd_i)
        begin
            unique case (addr_i)
                ADDR_T1_COUNT: next_rdata = cnt[IDX_T1];
                ADDR_T1_PERIOD: next_rdata = per[IDX_T1];
                ADDR_T1_CONTROL: next_rdata = con[IDX_T1];
                ADDR_LOW_COUNT: next_rdata = cnt[IDX_LOW];
                ADDR_HOLDING: next_rdata = hold;
                ADDR_HIGH_COUNT: next_rdata = cnt[IDX_HIGH];
                ADDR_LOW_PERIOD: next_rdata = per[IDX_LOW];
                ADDR_HIGH_PERIOD: next_rdata = per[IDX_HIGH];
                ADDR_LOW_CONTROL: next_rdata = con[IDX_LOW];
                ADDR_HIGH_CONTROL: next_rdata = con[IDX_HIGH];
                ADDR_IRQ_FLAGS: next_rdata = {13'h0000, flag};
                ADDR_IRQ_ENABLES: next_rdata = {13'h0000, ie};
                default: next_rdata = '0;
            endcase
        end
    end

    // shared state: flags, enables, holding word, sync stage, outputs
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            flag <= '0;
            ie <= '0;
            hold <= RST_COUNT;
            low_tick_q <= 1'b0;
            rdata_o <= '0;
            irq_o <= '0;
        end
        else
        begin
            flag <= next_flag;
            if (wr_i && addr_i == ADDR_IRQ_ENABLES)
                ie <= wdata_i[NUM_TIMERS-1:0];
            if (rd_low)
                hold <= cnt[IDX_HIGH];
            else if (wr_i && addr_i == ADDR_HOLDING)
                hold <= wdata_i;
            low_tick_q <= g_tmr[IDX_LOW].raw;
            rdata_o <= next_rdata;
            irq_o <= next_flag & ie;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wire t1_async = con[IDX_T1][BIT_ENABLE] && con[IDX_T1][BIT_CLK_SRC] && !con[IDX_T1][BIT_SYNC];
    wire any_wr_t1 = wr_i && (addr_i == ADDR_T1_COUNT);

    a_psc_frozen:
        assert property (!con[IDX_T1][BIT_ENABLE] && !wr_i |=> psc[IDX_T1] == $past(psc[IDX_T1]))
        else $error("prescaler moved while disabled");
    a_ctl_keeps_cnt:
        assert property (wr_i && addr_i == ADDR_T1_CONTROL && !tk[IDX_T1] |=> $stable(cnt[IDX_T1]))
        else $error("control write changed count");
    a_cnt_write:
        assert property (any_wr_t1 && con[IDX_T1][BIT_ENABLE] |=> psc[IDX_T1] == '0 && cnt[IDX_T1] == $past(wdata_i))
        else $error("count write not taken");
    a_wrap_zero:
        assert property (tk[IDX_T1] && cnt[IDX_T1] == per[IDX_T1] && !any_wr_t1 |=> cnt[IDX_T1] == RST_COUNT)
        else $error("timer did not wrap to zero");
    a_match_flag:
        assert property (tk[IDX_T1] && mt[IDX_T1] |=> flag[IDX_T1] ##1 (irq_o[IDX_T1] == ie[IDX_T1]) or !ie[IDX_T1])
        else $error("match flag missing");
    a_flag_sticky:
        assert property (flag[IDX_T1] && !wr_flags |=> flag[IDX_T1])
        else $error("flag lost without clear");
    a_gate_flag:
        assert property (gfall[IDX_T1] |=> flag[IDX_T1])
        else $error("gate fall flag missing");
    a_sleep_hold:
        assert property (cpu_sleep_i && !t1_async && !wr_i |=> $stable(cnt[IDX_T1]))
        else $error("timer counted in sleep");
    a_idle_hold:
        assert property (cpu_idle_i && con[IDX_LOW][BIT_IDLE_STOP] && !wr_i |=> $stable(cnt[IDX_LOW]))
        else $error("pair counted in idle");
    a_hold_read:
        assert property (rd_low |=> hold == $past(cnt[IDX_HIGH]))
        else $error("holding word not latched");
    a_hold_write:
        assert property (wr_low && m32 |=> cnt[IDX_HIGH] == $past(hold))
        else $error("high word not loaded");
    a_wrap32:
        assert property (m32 && tk[IDX_LOW] && mm32 && !wr_i |=> cnt[IDX_LOW] == '0 && cnt[IDX_HIGH] == '0 ##1 flag[IDX_HIGH])
        else $error("pair did not wrap at 32-bit period");

    // the request is the registered copy of flag and enable
    a_irq_follows:
        assert property (irq_o == $past(next_flag & ie))
        else $error("request does not follow flag");
    // read data stand only in the cycle after a read strobe
    a_rdata_idle:
        assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside answer cycle");
    // control reads return the stored bits
    a_ctl_read:
        assert property (rd_i && addr_i == ADDR_T1_CONTROL |=> rdata_o == $past(con[IDX_T1]))
        else $error("control read wrong");
    // unimplemented control bits never hold a one
    a_ctl_mask:
        assert property ((con[IDX_T1] & ~MASK_T1_CTL) == 16'h0000)
        else $error("unimplemented control bit set");
    // a clearing write drops the flag when no event competes
    a_flag_clear:
        assert property (flag[IDX_T1] && wr_flags && wdata_i[IDX_T1] && !set[IDX_T1] |=> !flag[IDX_T1])
        else $error("flag not cleared");
    // an event in the clearing cycle still wins
    a_set_wins:
        assert property (set[IDX_T1] |=> flag[IDX_T1])
        else $error("event lost to clear");
    // the low flag stays quiet while the pair runs as one timer
    a_pair_no_low:
        assert property (m32 && !flag[IDX_LOW] |=> !flag[IDX_LOW])
        else $error("low flag set in 32-bit mode");
    // high word only moves on a low word carry, a 32-bit period wrap, a holding load or its own count write
    a_hi_still:
        assert property (m32 && !wr_i && !(tk[IDX_LOW] && (mm32 || cnt[IDX_LOW] == CNT_MAX)) |=> $stable(cnt[IDX_HIGH]))
        else $error("high word moved without carry");
    // a low word rollover carries into the high word
    a_carry:
        assert property (m32 && tk[IDX_LOW] && cnt[IDX_LOW] == CNT_MAX && !mm32 && !wr_i
            |=> cnt[IDX_LOW] == 16'h0000 && cnt[IDX_HIGH] == $past(cnt[IDX_HIGH]) + 16'h0001)
        else $error("carry lost");
    // the low half's tick is its prescaler output one edge late
    a_low_sync:
        assert property (tk[IDX_LOW] == $past(g_tmr[IDX_LOW].raw))
        else $error("low tick not registered");
    // gate fall freezes the accumulated count
    a_gate_keep:
        assert property (gfall[IDX_T1] && !wr_i |=> $stable(cnt[IDX_T1]))
        else $error("count moved on gate fall");
    // the pair never counts in sleep once the sync stage has drained
    a_pair_sleep:
        assert property (cpu_sleep_i && $past(cpu_sleep_i) && !wr_i |=> $stable(cnt[IDX_LOW]))
        else $error("pair counted in sleep");
    // idle-stop also halts timer one
    a_idle_t1:
        assert property (cpu_idle_i && con[IDX_T1][BIT_IDLE_STOP] && !wr_i |=> $stable(cnt[IDX_T1]))
        else $error("timer one counted in idle");
    // enable register write
    a_ie_write:
        assert property (wr_i && addr_i == ADDR_IRQ_ENABLES |=> ie == $past(wdata_i[NUM_TIMERS-1:0]))
        else $error("enable write lost");
    // period register write and hold
    a_per_write:
        assert property (wr_i && addr_i == ADDR_T1_PERIOD |=> per[IDX_T1] == $past(wdata_i))
        else $error("period write lost");
    a_per_stable:
        assert property (!(wr_i && addr_i == ADDR_T1_PERIOD) |=> $stable(per[IDX_T1]))
        else $error("period changed unasked");
    // holding word changes only on a low read or its own write
    a_hold_keep:
        assert property (!rd_low && !(wr_i && addr_i == ADDR_HOLDING) |=> $stable(hold))
        else $error("holding word changed");
    // external mode ticks only on a sampled rising edge
    a_ext_tick:
        assert property (tk[IDX_T1] && con[IDX_T1][BIT_CLK_SRC] |-> t1_pin_i && !pin_q[IDX_T1])
        else $error("tick without pin edge");
    // gated mode ticks only while the gate is high
    a_gate_level:
        assert property (tk[IDX_T1] && con[IDX_T1][BIT_GATE] && !con[IDX_T1][BIT_CLK_SRC] |-> t1_pin_i)
        else $error("tick with gate low");
    // disabling by a control write clears the prescaler
    a_psc_off:
        assert property (wr_i && addr_i == ADDR_T1_CONTROL && con[IDX_T1][BIT_ENABLE] && !wdata_i[BIT_ENABLE]
            |=> psc[IDX_T1] == '0)
        else $error("prescaler kept on disable");

    c_t1_match: cover property (tk[IDX_T1] && mt[IDX_T1]);
    c_pair32_wrap: cover property (m32 && tk[IDX_LOW] && mm32);
    c_gate_end: cover property (gfall[IDX_LOW]);
    // sleep counting and a coherent 32-bit read
    c_sleep_tick: cover property (cpu_sleep_i && tk[IDX_T1]);
    c_hold_latch: cover property (rd_low && m32);
endmodule
`default_nettype wire

// File: testbench/gpt_pin_src.sv
// external clock and gate source that drives the timer pins
`timescale 1ns/1ns
`default_nettype none
module gpt_pin_src (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic gate_i,
    input wire logic [1:0] sel_i,
    input wire logic [7:0] len_i,
    input wire logic [3:0] half_i,
    output logic [2:0] pin_o,
    output logic done_o
);
    // pins rest low (pull-down) between bursts, so no stray edge reaches a counter
    initial
    begin
        pin_o = 3'h0;
        done_o = 1'b1;
        forever
        begin
            @(posedge clk_i);
            if (start_i)
            begin
                done_o <= 1'b0;
                if (gate_i)
                begin
                    // gate high for len cycles; its fall ends the accumulation
                    pin_o[sel_i] <= 1'b1;
                    repeat (len_i) @(posedge clk_i);
                    pin_o[sel_i] <= 1'b0;
                end
                else
                begin
                    // len rising edges, each level held half cycles
                    repeat (len_i)
                    begin
                        repeat (half_i) @(posedge clk_i);
                        pin_o[sel_i] <= 1'b1;
                        repeat (half_i) @(posedge clk_i);
                        pin_o[sel_i] <= 1'b0;
                    end
                end
                @(posedge clk_i);
                done_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/test_general_purpose_timers.sv
// self-checking testbench for the general purpose timers
`timescale 1ns/1ns
`default_nettype none
module test_general_purpose_timers import gpt_pkg::*; ;
    logic clk, rst_n, wr, rd, idle, sleep, p_start, p_gate, p_done;
    logic [15:0] addr, wdata, rdata, d, keep;
    logic [2:0] irq, pins;
    logic [1:0] p_sel;
    logic [7:0] p_len;
    logic [3:0] p_half;
    int fails, cmp_count, n, g;
    int divs[4] = '{1, 8, 64, 256};
    gpt_top i_dut (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .cpu_idle_i(idle), .cpu_sleep_i(sleep), .t1_pin_i(pins[0]), .pair_pin_i(pins[1]),
        .high_pin_i(pins[2]), .irq_o(irq));
    gpt_pin_src i_src (.clk_i(clk), .start_i(p_start), .gate_i(p_gate), .sel_i(p_sel), .len_i(p_len),
        .half_i(p_half), .pin_o(pins), .done_o(p_done));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test;
        $display("fails=%0d compares=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // range compare; an unknown never counts as inside the range
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        chk(d, lo, hi);
    endtask
    task automatic burst(input logic [1:0] s, input logic gt, input int len, input logic [3:0] h);
        @(posedge clk);
        p_start <= 1'b1;
        p_sel <= s;
        p_gate <= gt;
        p_len <= 8'(len);
        p_half <= h;
        @(posedge clk);
        p_start <= 1'b0;
        @(posedge clk);
        n = 0;
        while (p_done !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000)
        begin
            fails++;
            stop_test();
        end
        repeat (5) @(posedge clk);
    endtask
    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial
    begin
        {rst_n, wr, rd, idle, sleep, p_start, p_gate} = 7'h0;
        {addr, wdata, p_sel, p_len, p_half} = 46'h0;
        fails = 0;
        cmp_count = 0;
        void'($urandom(32'hd04a));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk(ADDR_T1_PERIOD, 16'hffff, 16'hffff);
        rchk(ADDR_T1_CONTROL, 16'h0000, 16'h0000);
        rchk(16'h0200, 16'h0000, 16'h0000);
        wreg(ADDR_T1_CONTROL, 16'hffff);
        rchk(ADDR_T1_CONTROL, 16'ha076, 16'ha076);
        // each prescale setting, six ticks' worth of cycles
        for (int k = 0; k < 4; k++)
        begin
            wreg(ADDR_T1_CONTROL, 16'(k << 4));
            wreg(ADDR_T1_COUNT, 16'h0000);
            wreg(ADDR_T1_CONTROL, 16'(16'h8000 | (k << 4)));
            repeat (6 * divs[k]) @(posedge clk);
            wreg(ADDR_T1_CONTROL, 16'(k << 4));
            rchk(ADDR_T1_COUNT, 16'h0005, 16'h0008);
            keep = d;
            wreg(ADDR_T1_CONTROL, 16'h0010);
            rchk(ADDR_T1_COUNT, keep, keep);
        end
        // a count write restarts the 1:256 prescaler, so no tick in 2x200 cycles
        wreg(ADDR_T1_CONTROL, 16'h8030);
        repeat (200) @(posedge clk);
        wreg(ADDR_T1_COUNT, 16'h0000);
        repeat (200) @(posedge clk);
        rchk(ADDR_T1_COUNT, 16'h0000, 16'h0000);
        // period match: flag without enable, then request, sticky until cleared
        wreg(ADDR_T1_CONTROL, 16'h0000);
        wreg(ADDR_T1_PERIOD, 16'h0003);
        wreg(ADDR_T1_COUNT, 16'h0000);
        wreg(ADDR_T1_CONTROL, 16'h8000);
        repeat (20) @(posedge clk);
        chk(16'(irq[0]), 16'h0000, 16'h0000);
        rchk(ADDR_IRQ_FLAGS, 16'h0001, 16'h0001);
        rchk(ADDR_T1_COUNT, 16'h0000, 16'h0003);
        wreg(ADDR_IRQ_ENABLES, 16'h0001);
        wreg(ADDR_T1_CONTROL, 16'h0000);
        repeat (10) @(posedge clk);
        chk(16'(irq[0]), 16'h0001, 16'h0001);
        wreg(ADDR_IRQ_FLAGS, 16'h0001);
        repeat (3) @(posedge clk);
        chk(16'(irq[0]), 16'h0000, 16'h0000);
        // external edges: synchronous counter, prompt then slow source
        wreg(ADDR_T1_PERIOD, 16'hffff);
        wreg(ADDR_T1_COUNT, 16'h0000);
        wreg(ADDR_T1_CONTROL, 16'h8006);
        burst(2'd0, 1'b0, 10, 4'd1);
        burst(2'd0, 1'b0, 5, 4'd4);
        rchk(ADDR_T1_COUNT, 16'd15, 16'd15);
        wreg(ADDR_T1_CONTROL, 16'ha006);
        idle <= 1'b1;
        burst(2'd0, 1'b0, 7, 4'd2);
        idle <= 1'b0;
        rchk(ADDR_T1_COUNT, 16'd15, 16'd15);
        wreg(ADDR_T1_CONTROL, 16'h8002);
        sleep <= 1'b1;
        burst(2'd0, 1'b0, 6, 4'd2);
        rchk(ADDR_T1_COUNT, 16'd21, 16'd21);
        wreg(ADDR_T1_CONTROL, 16'h8006);
        burst(2'd0, 1'b0, 6, 4'd2);
        sleep <= 1'b0;
        rchk(ADDR_T1_COUNT, 16'd21, 16'd21);
        // gated accumulation over a random gate length
        wreg(ADDR_T1_COUNT, 16'h0000);
        wreg(ADDR_IRQ_FLAGS, 16'h0007);
        wreg(ADDR_T1_CONTROL, 16'h8040);
        g = 20 + $urandom % 40;
        burst(2'd0, 1'b1, g, 4'd0);
        rchk(ADDR_T1_COUNT, 16'(g - 1), 16'(g + 1));
        keep = d;
        repeat (20) @(posedge clk);
        rchk(ADDR_T1_COUNT, keep, keep);
        rchk(ADDR_IRQ_FLAGS, 16'h0001, 16'h0001);
        // pair: coherent write through the holding register, coherent read
        wreg(ADDR_HOLDING, 16'h1234);
        wreg(ADDR_LOW_CONTROL, 16'h0008);
        wreg(ADDR_LOW_COUNT, 16'h5678);
        rchk(ADDR_HIGH_COUNT, 16'h1234, 16'h1234);
        wreg(ADDR_HOLDING, 16'haaaa);
        rchk(ADDR_LOW_COUNT, 16'h5678, 16'h5678);
        rchk(ADDR_HOLDING, 16'h1234, 16'h1234);
        // 32-bit match needs both words: no request while only the low word equals
        wreg(ADDR_LOW_PERIOD, 16'h0002);
        wreg(ADDR_HIGH_PERIOD, 16'h0001);
        wreg(ADDR_HOLDING, 16'h0000);
        wreg(ADDR_LOW_COUNT, 16'h0000);
        wreg(ADDR_IRQ_FLAGS, 16'h0007);
        wreg(ADDR_IRQ_ENABLES, 16'h0007);
        wreg(ADDR_HIGH_CONTROL, 16'h8000);
        wreg(ADDR_LOW_CONTROL, 16'h8008);
        repeat (100) @(posedge clk);
        chk(16'(irq[2]), 16'h0000, 16'h0000);
        wreg(ADDR_LOW_COUNT, 16'hfff0);
        repeat (40) @(posedge clk);
        chk(16'(irq[2:1]), 16'h0002, 16'h0002);
        rchk(ADDR_LOW_COUNT, 16'h0000, 16'h0020);
        rchk(ADDR_HOLDING, 16'h0000, 16'h0000);
        // 32-bit synchronous counter on the pair pin
        wreg(ADDR_LOW_CONTROL, 16'h000a);
        wreg(ADDR_LOW_COUNT, 16'h0000);
        wreg(ADDR_LOW_CONTROL, 16'h800a);
        burst(2'd1, 1'b0, 9, 4'd1);
        rchk(ADDR_LOW_COUNT, 16'd9, 16'd9);
        stop_test();
    end
endmodule
`default_nettype wire
